/* File: hdl/ssfs_pkg.sv */
package ssfs_pkg;
    // register addresses as seen from the serial or fieldbus link
    localparam logic [15:0] ADDR_FAULT_PRI = 16'h1f00;
    localparam logic [15:0] ADDR_FAULT_SEC = 16'h2000;
    localparam logic [15:0] ADDR_CFG_STORE = 16'h2910;
    localparam logic [15:0] ADDR_MOT_STORE = 16'h2930;
    localparam logic [15:0] ADDR_QS_DECEL_LO = 16'h3300;
    localparam logic [15:0] ADDR_QS_DECEL_HI = 16'h3301;
    localparam logic [15:0] ADDR_QS_ACTION = 16'h3400;
    localparam logic [15:0] ADDR_SD_ACTION = 16'h3410;
    localparam logic [15:0] ADDR_DIS_ACTION = 16'h3420;
    localparam logic [15:0] ADDR_PAUSE_ACTION = 16'h3430;
    localparam logic [15:0] ADDR_FLT_ACTION = 16'h3440;
    localparam logic [15:0] ADDR_TZ_DECEL_LO = 16'h4c00;
    localparam logic [15:0] ADDR_TZ_DECEL_HI = 16'h4c01;
    localparam logic [15:0] ADDR_TEMP_LIMIT = 16'h7180;
    localparam logic [15:0] ADDR_TEMP_READ = 16'h7190;
    localparam logic [15:0] ADDR_UV_LIMIT = 16'h8670;
    localparam logic [15:0] ADDR_CHOP_POINT = 16'h8680;
    localparam logic [15:0] ADDR_OV_LIMIT = 16'h8690;

    // reset values
    localparam logic [15:0] RST_FAULT_PRI = 16'h0408;
    localparam logic [15:0] RST_FAULT_SEC = 16'h0000;
    localparam logic [15:0] RST_ACTION = 16'h0000;
    localparam logic [15:0] RST_PAUSE_ACTION = 16'h0001;
    localparam logic [31:0] RST_QS_DECEL = 32'h0000ee48;
    localparam logic [31:0] RST_TZ_DECEL = 32'h00002710;
    localparam logic [15:0] RST_TEMP_LIMIT = 16'h0064;
    localparam logic [15:0] RST_UV_LIMIT = 16'h0012;
    localparam logic [15:0] RST_CHOP_POINT = 16'h003f;
    localparam logic [15:0] RST_OV_LIMIT = 16'h0046;
    localparam logic [15:0] TEMP_NO_SENSOR = 16'hffd8;

    // command and mode codes
    localparam logic [7:0] CMD_STORE = 8'h01;
    localparam logic [7:0] CMD_INIT = 8'h0a;
    localparam logic [15:0] CTRL_QUICK_STOP = 16'h000b;
    localparam int CTRL_PAUSE_BIT = 8;
    localparam logic [15:0] MODE_COAST = 16'h0000;
    localparam logic [15:0] MODE_RAMP_OFF = 16'h0001;
    localparam logic [15:0] MODE_QSD_OFF = 16'h0002;
    localparam logic [15:0] MODE_PROFILE_HOLD = 16'h0005;
    localparam logic [15:0] MODE_QSD_HOLD = 16'h0006;
    localparam logic [15:0] MODE_WINDING = 16'h0012;
    localparam logic [7:0] WORK_MODE_A = 8'h01;
    localparam logic [7:0] WORK_MODE_B = 8'h03;

    // fault bit positions fed by the threshold comparators, and the reserved bit mask of the secondary word
    localparam int FP_OVERVOLT = 5;
    localparam int FP_UNDERVOLT = 6;
    localparam int FP_MOTOR_TEMP = 13;
    localparam logic [15:0] SEC_RESERVED_MASK = 16'h00e0;

    typedef enum logic [5:0] {
        SSFS_IDLE = 6'b000001,
        SSFS_FAULT = 6'b000010,
        SSFS_QSTOP = 6'b000100,
        SSFS_SHUTDOWN = 6'b001000,
        SSFS_DISABLE = 6'b010000,
        SSFS_PAUSE = 6'b100000
    } ssfs_state_t;
endpackage : ssfs_pkg

/* File: hdl/ssfs_regs.sv */
`timescale 1ns/1ps
module ssfs_regs (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [15:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    output logic REG_ERR,
    input wire logic [15:0] CTRL_WORD,
    input wire logic [7:0] WORK_MODE,
    input wire logic DISABLE_REQ,
    input wire logic LIMIT_POS_PIN,
    input wire logic LIMIT_NEG_PIN,
    input wire logic ESTOP_PIN,
    input wire logic DRIVE_ENABLE_PIN,
    input wire logic [15:0] FAULT_SRC_PRI,
    input wire logic [15:0] FAULT_SRC_SEC,
    input wire logic [15:0] MOTOR_TEMP_RAW,
    input wire logic TEMP_SENSOR_OK,
    input wire logic [15:0] BUS_VOLTAGE,
    output logic STORE_CONFIG,
    output logic INIT_CONFIG,
    output logic STORE_MOTOR,
    output ssfs_pkg::ssfs_state_t STOP_STATE,
    output logic [15:0] STOP_ACTION,
    output logic [31:0] DECEL_VALUE,
    output logic SWITCH_OFF,
    output logic CHOPPER_ON,
    output logic TEMP_ALARM,
    output logic UNDERVOLT_ALARM,
    output logic OVERVOLT_ALARM
);
    import ssfs_pkg::*;

    logic [7:0] cfg_cmd_reg;
    logic [7:0] mot_cmd_reg;
    logic [31:0] qs_decel_reg;
    logic [31:0] tz_decel_reg;
    logic [15:0] qs_action_reg;
    logic [15:0] sd_action_reg;
    logic [15:0] dis_action_reg;
    logic [15:0] pause_action_reg;
    logic [15:0] flt_action_reg;
    logic [15:0] temp_limit_reg;
    logic [15:0] uv_limit_reg;
    logic [15:0] chop_point_reg;
    logic [15:0] ov_limit_reg;
    logic [15:0] fault_pri_reg;
    logic [15:0] fault_sec_reg;
    logic [15:0] temp_read_reg;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic enable_prev_reg;
    ssfs_state_t state_reg;
    ssfs_state_t state_next;
    logic [15:0] rdata_next;
    logic rerr_next;
    logic quick_cause;
    logic shutdown_cause;
    logic fault_cause;
    logic pause_cause;
    logic [15:0] action_next;
    logic [31:0] decel_next;
    logic off_next;

    // pins are asynchronous to CLK; only the second stage is ever read
    // bits: 0 positive limit, 1 negative limit, 2 emergency stop, 3 enable
    // the edge register resets low, so no false enable edge after reset
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            enable_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {DRIVE_ENABLE_PIN, ESTOP_PIN,
                LIMIT_NEG_PIN, LIMIT_POS_PIN};
            sync2_reg <= sync1_reg;
            enable_prev_reg <= sync2_reg[3];
        end
    end

    // storage commands: the written code is kept, only exact codes pulse
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cfg_cmd_reg <= 8'h00;
            mot_cmd_reg <= 8'h00;
            STORE_CONFIG <= 1'b0;
            INIT_CONFIG <= 1'b0;
            STORE_MOTOR <= 1'b0;
        end else begin
            STORE_CONFIG <= 1'b0;
            INIT_CONFIG <= 1'b0;
            STORE_MOTOR <= 1'b0;
            if (REG_WR && REG_ADDR == ADDR_CFG_STORE) begin
                cfg_cmd_reg <= REG_WDATA[7:0];
                // control loop set only; the motor store strobe stays low
                // the upper byte must be zero: 0x0101 is no command
                STORE_CONFIG <= (REG_WDATA == {8'h00, CMD_STORE});
                INIT_CONFIG <= (REG_WDATA == {8'h00, CMD_INIT});
            end
            if (REG_WR && REG_ADDR == ADDR_MOT_STORE) begin
                mot_cmd_reg <= REG_WDATA[7:0];
                STORE_MOTOR <= (REG_WDATA == {8'h00, CMD_STORE});
            end
        end
    end

    // stop behaviour and threshold settings
    // each half of a 32-bit deceleration takes effect on its own write,
    // so a host changing both halves briefly runs on a mixed value
    // read-only and unmapped addresses fall through the case silently
    always_ff @(posedge CLK) begin
        if (SRST) begin
            qs_decel_reg <= RST_QS_DECEL;
            tz_decel_reg <= RST_TZ_DECEL;
            qs_action_reg <= RST_ACTION;
            sd_action_reg <= RST_ACTION;
            dis_action_reg <= RST_ACTION;
            pause_action_reg <= RST_PAUSE_ACTION;
            flt_action_reg <= RST_ACTION;
            temp_limit_reg <= RST_TEMP_LIMIT;
            uv_limit_reg <= RST_UV_LIMIT;
            chop_point_reg <= RST_CHOP_POINT;
            ov_limit_reg <= RST_OV_LIMIT;
        end else if (REG_WR) begin
            unique case (REG_ADDR)
                ADDR_QS_DECEL_LO: qs_decel_reg[15:0] <= REG_WDATA;
                ADDR_QS_DECEL_HI: qs_decel_reg[31:16] <= REG_WDATA;
                ADDR_TZ_DECEL_LO: tz_decel_reg[15:0] <= REG_WDATA;
                ADDR_TZ_DECEL_HI: tz_decel_reg[31:16] <= REG_WDATA;
                ADDR_QS_ACTION: qs_action_reg <= REG_WDATA;
                ADDR_SD_ACTION: sd_action_reg <= REG_WDATA;
                ADDR_DIS_ACTION: dis_action_reg <= REG_WDATA;
                ADDR_PAUSE_ACTION: pause_action_reg <= REG_WDATA;
                ADDR_FLT_ACTION: flt_action_reg <= REG_WDATA;
                ADDR_TEMP_LIMIT: temp_limit_reg <= REG_WDATA;
                ADDR_UV_LIMIT: uv_limit_reg <= REG_WDATA;
                ADDR_CHOP_POINT: chop_point_reg <= REG_WDATA;
                ADDR_OV_LIMIT: ov_limit_reg <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // live monitoring; alarm outputs and fault bits come from the same compare
    // temperature compares signed so readings below zero work; with no
    // sensor the -40 reading must not raise the alarm
    always_ff @(posedge CLK) begin
        if (SRST) begin
            temp_read_reg <= TEMP_NO_SENSOR;
            TEMP_ALARM <= 1'b0;
            UNDERVOLT_ALARM <= 1'b0;
            OVERVOLT_ALARM <= 1'b0;
            CHOPPER_ON <= 1'b0;
        end else begin
            temp_read_reg <= TEMP_SENSOR_OK ? MOTOR_TEMP_RAW :
                TEMP_NO_SENSOR;
            TEMP_ALARM <= TEMP_SENSOR_OK &&
                ($signed(MOTOR_TEMP_RAW) >= $signed(temp_limit_reg));
            UNDERVOLT_ALARM <= (BUS_VOLTAGE < uv_limit_reg);
            CHOPPER_ON <= (BUS_VOLTAGE > chop_point_reg);
            OVERVOLT_ALARM <= (BUS_VOLTAGE > ov_limit_reg);
        end
    end

    // fault words are real time, not sticky: they follow their sources
    // alarm bits arrive one cycle after the alarm outputs, so a threshold
    // fault shows two cycles after the input moves
    always_ff @(posedge CLK) begin
        if (SRST) begin
            fault_pri_reg <= RST_FAULT_PRI;
            fault_sec_reg <= RST_FAULT_SEC;
        end else begin
            fault_pri_reg <= FAULT_SRC_PRI;
            fault_pri_reg[FP_OVERVOLT] <= FAULT_SRC_PRI[FP_OVERVOLT] |
                OVERVOLT_ALARM;
            fault_pri_reg[FP_UNDERVOLT] <= FAULT_SRC_PRI[FP_UNDERVOLT] |
                UNDERVOLT_ALARM;
            fault_pri_reg[FP_MOTOR_TEMP] <= FAULT_SRC_PRI[FP_MOTOR_TEMP] |
                TEMP_ALARM;
            fault_sec_reg <= FAULT_SRC_SEC & ~SEC_RESERVED_MASK;
        end
    end

    // limits and emergency stop act as levels, the control word only on its exact code
    assign quick_cause = sync2_reg[0] |
        sync2_reg[1] |
        sync2_reg[2] |
        (CTRL_WORD == CTRL_QUICK_STOP);
    assign shutdown_cause = enable_prev_reg & ~sync2_reg[3];
    // reserved bits of the secondary word are already masked out
    assign fault_cause = (fault_pri_reg != 16'h0000) |
        (fault_sec_reg != 16'h0000);
    assign pause_cause = CTRL_WORD[CTRL_PAUSE_BIT];

    // priority: fault, quick stop, shutdown, disable, pause.
    // a stop is held while its cause lasts; shutdown is an edge, so it
    // holds until the drive is enabled again
    always_comb begin
        state_next = state_reg;
        if (fault_cause) begin
            state_next = SSFS_FAULT;
        end else if (quick_cause) begin
            state_next = SSFS_QSTOP;
        end else if (shutdown_cause) begin
            state_next = SSFS_SHUTDOWN;
        end else if (DISABLE_REQ) begin
            state_next = SSFS_DISABLE;
        end else if (pause_cause) begin
            state_next = SSFS_PAUSE;
        end else if (state_reg != SSFS_SHUTDOWN || sync2_reg[3]) begin
            state_next = SSFS_IDLE;
        end
    end

    // action code, deceleration and switch-off for the chosen stop
    // an undocumented code passes through as the action; only switch-off
    // and deceleration look at the code itself
    always_comb begin
        action_next = MODE_COAST;
        decel_next = tz_decel_reg;
        off_next = 1'b0;
        unique case (state_next)
            SSFS_IDLE: begin
                action_next = MODE_COAST;
                off_next = 1'b0;
            end
            SSFS_FAULT: begin
                action_next = flt_action_reg;
            end
            SSFS_QSTOP: begin
                action_next = qs_action_reg;
            end
            SSFS_SHUTDOWN: begin
                action_next = sd_action_reg;
            end
            SSFS_DISABLE: begin
                action_next = dis_action_reg;
            end
            SSFS_PAUSE: begin
                action_next = pause_action_reg;
            end
        endcase
        if (state_next != SSFS_IDLE) begin
            // pause keeps the motor enabled whatever its code
            off_next = (state_next != SSFS_PAUSE) &&
                (action_next == MODE_COAST || action_next == MODE_RAMP_OFF ||
                 action_next == MODE_QSD_OFF || action_next == MODE_WINDING);
            // quick stop deceleration for both quick stop codes, profile for the holding code;
            // for every other code the quick stop state keeps its own, other stops use profile
            if (action_next == MODE_QSD_OFF || action_next == MODE_QSD_HOLD) begin
                decel_next = qs_decel_reg;
            end else if (action_next == MODE_PROFILE_HOLD) begin
                decel_next = tz_decel_reg;
            end else if (state_next == SSFS_QSTOP) begin
                decel_next = qs_decel_reg;
            end
        end else if (WORK_MODE == WORK_MODE_A || WORK_MODE == WORK_MODE_B) begin
            decel_next = tz_decel_reg;
        end
    end

    // all stop outputs launch on one edge, so state and action never disagree
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_reg <= SSFS_IDLE;
            STOP_STATE <= SSFS_IDLE;
            STOP_ACTION <= MODE_COAST;
            DECEL_VALUE <= RST_TZ_DECEL;
            SWITCH_OFF <= 1'b0;
        end else begin
            state_reg <= state_next;
            STOP_STATE <= state_next;
            STOP_ACTION <= action_next;
            DECEL_VALUE <= decel_next;
            SWITCH_OFF <= off_next;
        end
    end

    // read mux; unmapped addresses answer zero with an error flag
    always_comb begin
        rdata_next = 16'h0000;
        rerr_next = 1'b0;
        unique case (REG_ADDR)
            ADDR_FAULT_PRI: rdata_next = fault_pri_reg;
            ADDR_FAULT_SEC: rdata_next = fault_sec_reg;
            ADDR_CFG_STORE: rdata_next = {8'h00, cfg_cmd_reg};
            ADDR_MOT_STORE: rdata_next = {8'h00, mot_cmd_reg};
            ADDR_QS_DECEL_LO: rdata_next = qs_decel_reg[15:0];
            ADDR_QS_DECEL_HI: rdata_next = qs_decel_reg[31:16];
            ADDR_TZ_DECEL_LO: rdata_next = tz_decel_reg[15:0];
            ADDR_TZ_DECEL_HI: rdata_next = tz_decel_reg[31:16];
            ADDR_QS_ACTION: rdata_next = qs_action_reg;
            ADDR_SD_ACTION: rdata_next = sd_action_reg;
            ADDR_DIS_ACTION: rdata_next = dis_action_reg;
            ADDR_PAUSE_ACTION: rdata_next = pause_action_reg;
            ADDR_FLT_ACTION: rdata_next = flt_action_reg;
            ADDR_TEMP_LIMIT: rdata_next = temp_limit_reg;
            ADDR_TEMP_READ: rdata_next = temp_read_reg;
            ADDR_UV_LIMIT: rdata_next = uv_limit_reg;
            ADDR_CHOP_POINT: rdata_next = chop_point_reg;
            ADDR_OV_LIMIT: rdata_next = ov_limit_reg;
            default: rerr_next = 1'b1;
        endcase
    end

    // data reads zero outside a read, so a stale word never sits on the bus
    always_ff @(posedge CLK) begin
        if (SRST) begin
            REG_RDATA <= 16'h0000;
            REG_RVALID <= 1'b0;
            REG_ERR <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            REG_RDATA <= REG_RD ? rdata_next : 16'h0000;
            REG_ERR <= REG_RD & rerr_next;
        end
    end
endmodule : ssfs_regs

/* File: verif/ssfs_host.sv */
`timescale 1ns/1ps
module ssfs_host (
    input wire logic CLK,
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic REG_ERR,
    output logic [15:0] REG_ADDR,
    output logic REG_WR,
    output logic REG_RD,
    output logic [15:0] REG_WDATA
);
    initial begin
        REG_ADDR = 16'h0000;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_WDATA = 16'h0000;
    end
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
        // released data shows garbage so a late sample cannot pass by luck
        REG_WDATA <= ~d;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic e);
        int i;
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        i = 0;
        do begin
            @(posedge CLK);
            i++;
        end while (REG_RVALID !== 1'b1 && i < 4);
        d = REG_RDATA;
        e = REG_RVALID ? REG_ERR : 1'bx;
    endtask : rd
endmodule : ssfs_host

/* File: verif/ssfs_regs_props.sv */
`timescale 1ns/1ps
module ssfs_regs_props
    import ssfs_pkg::*;
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [15:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic REG_ERR,
    input wire logic [15:0] CTRL_WORD,
    input wire logic [15:0] FAULT_SRC_PRI,
    input wire logic [15:0] FAULT_SRC_SEC,
    input wire logic TEMP_SENSOR_OK,
    input wire logic STORE_CONFIG,
    input wire logic INIT_CONFIG,
    input wire logic STORE_MOTOR,
    input wire ssfs_pkg::ssfs_state_t STOP_STATE,
    input wire logic [15:0] STOP_ACTION,
    input wire logic TEMP_ALARM,
    input wire logic UNDERVOLT_ALARM,
    input wire logic OVERVOLT_ALARM
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    wire logic cfg_req = REG_WR && REG_ADDR == ADDR_CFG_STORE && REG_WDATA == 16'h0001;
    wire logic init_req = REG_WR && REG_ADDR == ADDR_CFG_STORE && REG_WDATA == 16'h000a;
    wire logic mot_req = REG_WR && REG_ADDR == ADDR_MOT_STORE && REG_WDATA == 16'h0001;
    // no fault cause now or in the last three cycles, so the fault word lag cannot win
    wire logic calm_now = FAULT_SRC_PRI == 16'h0000 && (FAULT_SRC_SEC & ~16'h00e0) == 16'h0000
        && !TEMP_ALARM && !UNDERVOLT_ALARM && !OVERVOLT_ALARM;
    logic [2:0] calm_reg;
    always_ff @(posedge CLK) begin
        calm_reg <= {calm_reg[1:0], calm_now && !SRST};
    end
    a_cfg_store: assert property (cfg_req |=> STORE_CONFIG) else $error("config store missing");
    a_cfg_init: assert property (init_req |=> INIT_CONFIG ##1 !INIT_CONFIG) else $error("init pulse wrong");
    a_motor_store: assert property (mot_req |=> STORE_MOTOR) else $error("motor store missing");
    a_store_apart: assert property (STORE_CONFIG |-> !STORE_MOTOR && !INIT_CONFIG) else $error("store mix");
    a_store_cause: assert property (STORE_CONFIG |-> $past(cfg_req)) else $error("spurious store");
    a_read_answer: assert property (REG_RD |=> REG_RVALID) else $error("read not answered");
    a_err_data: assert property (REG_ERR |-> REG_RVALID && REG_RDATA == 16'h0000) else $error("err data");
    a_sec_reserved: assert property (REG_RVALID && $past(REG_ADDR) == ADDR_FAULT_SEC
        |-> (REG_RDATA & SEC_RESERVED_MASK) == 16'h0000) else $error("reserved bits set");
    a_quick_entry: assert property (CTRL_WORD == CTRL_QUICK_STOP && calm_now && &calm_reg
        |=> STOP_STATE == SSFS_QSTOP) else $error("quick stop missed");
    a_idle_action: assert property (STOP_STATE == SSFS_IDLE |-> STOP_ACTION == 16'h0000) else $error("idle action");
    a_no_sensor: assert property (!TEMP_SENSOR_OK |=> !TEMP_ALARM) else $error("alarm without sensor");
    c_store: cover property (cfg_req ##1 STORE_CONFIG);
    c_quick: cover property (STOP_STATE == SSFS_QSTOP);
    c_err: cover property (REG_ERR);
endmodule : ssfs_regs_props

bind ssfs_regs ssfs_regs_props ssfs_regs_props_i (.CLK, .SRST, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA,
    .REG_RDATA, .REG_RVALID, .REG_ERR, .CTRL_WORD, .FAULT_SRC_PRI, .FAULT_SRC_SEC, .TEMP_SENSOR_OK,
    .STORE_CONFIG, .INIT_CONFIG, .STORE_MOTOR, .STOP_STATE, .STOP_ACTION, .TEMP_ALARM, .UNDERVOLT_ALARM,
    .OVERVOLT_ALARM);

/* File: verif/test_servo_store_fault_stop_regs.sv */
`timescale 1ns/1ps
module test_servo_store_fault_stop_regs;
    import ssfs_pkg::*;
    typedef struct packed {logic [15:0] a; logic w; logic [15:0] d; logic [15:0] e;} ssfs_row_t;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, CTRL_WORD, FAULT_SRC_PRI, FAULT_SRC_SEC, MOTOR_TEMP_RAW;
    logic [15:0] BUS_VOLTAGE, STOP_ACTION;
    logic REG_WR, REG_RD, REG_RVALID, REG_ERR, DISABLE_REQ, LIMIT_POS_PIN, LIMIT_NEG_PIN, ESTOP_PIN;
    logic DRIVE_ENABLE_PIN, TEMP_SENSOR_OK, STORE_CONFIG, INIT_CONFIG, STORE_MOTOR, SWITCH_OFF;
    logic CHOPPER_ON, TEMP_ALARM, UNDERVOLT_ALARM, OVERVOLT_ALARM;
    logic [7:0] WORK_MODE;
    logic [31:0] DECEL_VALUE;
    ssfs_state_t STOP_STATE;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    ssfs_row_t rows [18] = '{'{16'h2910, 0, 0, 16'h0000}, '{16'h2930, 0, 0, 16'h0000}, '{16'h3300, 0, 0, 16'hee48},
        '{16'h3301, 0, 0, 16'h0000}, '{16'h3400, 0, 0, 16'h0000}, '{16'h3410, 0, 0, 16'h0000},
        '{16'h3420, 0, 0, 16'h0000}, '{16'h3430, 0, 0, 16'h0001}, '{16'h3440, 0, 0, 16'h0000},
        '{16'h4c00, 0, 0, 16'h2710}, '{16'h7180, 0, 0, 16'h0064}, '{16'h8670, 0, 0, 16'h0012},
        '{16'h8680, 0, 0, 16'h003f}, '{16'h8690, 0, 0, 16'h0046}, '{16'h2000, 0, 0, 16'h0000},
        '{16'h1f00, 1, 16'hffff, 16'h0000}, '{16'h2000, 1, 16'hffff, 16'h0000}, '{16'h3420, 1, 16'h0012, 16'h0012}};
    logic [15:0] st_a [5] = '{ADDR_CFG_STORE, ADDR_CFG_STORE, ADDR_MOT_STORE, ADDR_CFG_STORE, ADDR_MOT_STORE};
    logic [15:0] st_d [5] = '{16'h0001, 16'h000a, 16'h0001, 16'h0002, 16'h000a};
    logic [2:0] st_e [5] = '{3'b100, 3'b010, 3'b001, 3'b000, 3'b000};
    logic [15:0] qc [6] = '{MODE_COAST, MODE_RAMP_OFF, MODE_QSD_OFF, MODE_PROFILE_HOLD, MODE_QSD_HOLD, MODE_WINDING};
    logic [15:0] volts [6] = '{16'd17, 16'd18, 16'd63, 16'd64, 16'd70, 16'd71};
    always #5 CLK = ~CLK;
    ssfs_host ssfs_host_i (.CLK(CLK), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .REG_ERR(REG_ERR),
        .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA));
    ssfs_regs ssfs_regs_i (.CLK(CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .REG_ERR(REG_ERR),
        .CTRL_WORD(CTRL_WORD), .WORK_MODE(WORK_MODE), .DISABLE_REQ(DISABLE_REQ), .LIMIT_POS_PIN(LIMIT_POS_PIN),
        .LIMIT_NEG_PIN(LIMIT_NEG_PIN), .ESTOP_PIN(ESTOP_PIN), .DRIVE_ENABLE_PIN(DRIVE_ENABLE_PIN),
        .FAULT_SRC_PRI(FAULT_SRC_PRI), .FAULT_SRC_SEC(FAULT_SRC_SEC), .MOTOR_TEMP_RAW(MOTOR_TEMP_RAW),
        .TEMP_SENSOR_OK(TEMP_SENSOR_OK), .BUS_VOLTAGE(BUS_VOLTAGE), .STORE_CONFIG(STORE_CONFIG),
        .INIT_CONFIG(INIT_CONFIG), .STORE_MOTOR(STORE_MOTOR), .STOP_STATE(STOP_STATE), .STOP_ACTION(STOP_ACTION),
        .DECEL_VALUE(DECEL_VALUE), .SWITCH_OFF(SWITCH_OFF), .CHOPPER_ON(CHOPPER_ON), .TEMP_ALARM(TEMP_ALARM),
        .UNDERVOLT_ALARM(UNDERVOLT_ALARM), .OVERVOLT_ALARM(OVERVOLT_ALARM));
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic er;
        ssfs_host_i.rd(a, d, er);
        chk({15'h0000, er, d}, {16'h0000, e});
    endtask : rdchk
    // waits a bounded time for the stop state, then checks the action it carries
    task automatic stopchk(input ssfs_state_t s, input logic [15:0] act);
        int i;
        for (i = 0; i < 8 && STOP_STATE !== s; i++) @(posedge CLK);
        chk({26'h0, STOP_STATE}, {26'h0, s});
        chk({16'h0, STOP_ACTION}, {16'h0, act});
    endtask : stopchk
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        logic [15:0] d;
        logic er;
        CTRL_WORD <= 16'h0000;
        WORK_MODE <= WORK_MODE_A;
        {DISABLE_REQ, LIMIT_POS_PIN, LIMIT_NEG_PIN, ESTOP_PIN} <= 4'h0;
        DRIVE_ENABLE_PIN <= 1'b1;
        FAULT_SRC_PRI <= 16'h0000;
        FAULT_SRC_SEC <= 16'h0000;
        MOTOR_TEMP_RAW <= 16'd25;
        TEMP_SENSOR_OK <= 1'b1;
        BUS_VOLTAGE <= 16'd48;
        repeat (10) @(posedge CLK);
        SRST <= 1'b0;
        foreach (rows[k]) begin
            if (rows[k].w) ssfs_host_i.wr(rows[k].a, rows[k].d);
            rdchk(rows[k].a, rows[k].e);
        end
        ssfs_host_i.rd(16'h1234, d, er);
        chk({er, d}, {1'b1, 16'h0000});
        foreach (st_a[k]) begin
            ssfs_host_i.wr(st_a[k], st_d[k]);
            @(posedge CLK);
            chk({STORE_CONFIG, INIT_CONFIG, STORE_MOTOR}, st_e[k]);
        end
        foreach (qc[k]) begin
            ssfs_host_i.wr(ADDR_QS_ACTION, qc[k]);
            CTRL_WORD <= CTRL_QUICK_STOP;
            stopchk(SSFS_QSTOP, qc[k]);
            chk(DECEL_VALUE, qc[k] == MODE_PROFILE_HOLD ? RST_TZ_DECEL : RST_QS_DECEL);
            chk(SWITCH_OFF, qc[k] != MODE_PROFILE_HOLD && qc[k] != MODE_QSD_HOLD);
            CTRL_WORD <= 16'h0000;
            stopchk(SSFS_IDLE, 16'h0000);
        end
        ESTOP_PIN <= 1'b1;
        stopchk(SSFS_QSTOP, MODE_WINDING);
        ESTOP_PIN <= 1'b0;
        stopchk(SSFS_IDLE, 16'h0000);
        LIMIT_NEG_PIN <= 1'b1;
        stopchk(SSFS_QSTOP, MODE_WINDING);
        LIMIT_NEG_PIN <= 1'b0;
        stopchk(SSFS_IDLE, 16'h0000);
        LIMIT_POS_PIN <= 1'b1;
        stopchk(SSFS_QSTOP, MODE_WINDING);
        LIMIT_POS_PIN <= 1'b0;
        stopchk(SSFS_IDLE, 16'h0000);
        ssfs_host_i.wr(ADDR_PAUSE_ACTION, 16'h0002);
        CTRL_WORD <= 16'h0100;
        stopchk(SSFS_PAUSE, 16'h0002);
        chk(DECEL_VALUE, RST_QS_DECEL);
        CTRL_WORD <= 16'h0000;
        DISABLE_REQ <= 1'b1;
        stopchk(SSFS_DISABLE, MODE_WINDING);
        chk(SWITCH_OFF, 1'b1);
        DISABLE_REQ <= 1'b0;
        ssfs_host_i.wr(ADDR_SD_ACTION, MODE_RAMP_OFF);
        DRIVE_ENABLE_PIN <= 1'b0;
        stopchk(SSFS_SHUTDOWN, MODE_RAMP_OFF);
        DRIVE_ENABLE_PIN <= 1'b1;
        ssfs_host_i.wr(ADDR_FLT_ACTION, MODE_QSD_OFF);
        FAULT_SRC_PRI <= 16'h8001;
        FAULT_SRC_SEC <= 16'hffff;
        CTRL_WORD <= CTRL_QUICK_STOP;
        stopchk(SSFS_FAULT, MODE_QSD_OFF);
        rdchk(ADDR_FAULT_PRI, 16'h8001);
        rdchk(ADDR_FAULT_SEC, 16'hff1f);
        CTRL_WORD <= 16'h0000;
        {FAULT_SRC_PRI, FAULT_SRC_SEC} <= 32'h0;
        stopchk(SSFS_IDLE, 16'h0000);
        foreach (volts[k]) begin
            BUS_VOLTAGE <= volts[k];
            repeat (3) @(posedge CLK);
            chk({UNDERVOLT_ALARM, CHOPPER_ON, OVERVOLT_ALARM}, {volts[k] < RST_UV_LIMIT,
                volts[k] > RST_CHOP_POINT, volts[k] > RST_OV_LIMIT});
            rdchk(ADDR_FAULT_PRI, {9'h0, volts[k] < RST_UV_LIMIT, volts[k] > RST_OV_LIMIT, 5'h0});
        end
        BUS_VOLTAGE <= 16'd48;
        MOTOR_TEMP_RAW <= 16'd100;
        repeat (3) @(posedge CLK);
        chk(TEMP_ALARM, 1'b1);
        MOTOR_TEMP_RAW <= 16'd99;
        repeat (3) @(posedge CLK);
        chk(TEMP_ALARM, 1'b0);
        MOTOR_TEMP_RAW <= 16'd200;
        TEMP_SENSOR_OK <= 1'b0;
        repeat (3) @(posedge CLK);
        chk(TEMP_ALARM, 1'b0);
        rdchk(ADDR_TEMP_READ, TEMP_NO_SENSOR);
        TEMP_SENSOR_OK <= 1'b1;
        MOTOR_TEMP_RAW <= 16'd25;
        stopchk(SSFS_IDLE, 16'h0000);
        ssfs_host_i.wr(ADDR_TZ_DECEL_LO, 16'h1234);
        WORK_MODE <= WORK_MODE_B;
        repeat (2) @(posedge CLK);
        chk(DECEL_VALUE, 32'h00001234);
        // mid-run reset: settings return to their defaults
        SRST <= 1'b1;
        repeat (2) @(posedge CLK);
        chk(DECEL_VALUE, RST_TZ_DECEL);
        chk({26'h0, STOP_STATE}, {26'h0, SSFS_IDLE});
        SRST <= 1'b0;
        rdchk(ADDR_PAUSE_ACTION, RST_PAUSE_ACTION);
        rdchk(ADDR_TZ_DECEL_LO, RST_TZ_DECEL[15:0]);
        stop_test();
    end
endmodule : test_servo_store_fault_stop_regs
